/* hsc_pkg.sv */
// package for the halt standby controller: opcodes, vectors, states, carriers
// assumes an 8-bit core with a 12-bit program counter
package hsc_pkg;

    localparam logic [7:0]  HALT_OPCODE     = 8'h01;
    localparam logic [11:0] RESET_VECTOR    = 12'h000;
    localparam logic [11:0] EXT_INT_VECTOR  = 12'h003;
    localparam logic [11:0] PC_RESET        = 12'h000;
    localparam logic        IE_RESET        = 1'b0;
    localparam logic [1:0]  SYNC_RESET      = 2'h3;

    typedef enum logic [1:0] {
        HSC_RUN   = 2'b00,
        HSC_HALT  = 2'b01,
        HSC_WAKE  = 2'b10
    } hsc_state_type;

    // what the core tells the controller each cycle
    typedef struct packed {
        logic        exec;
        logic [7:0]  opcode;
        logic [11:0] next_pc;
        logic        ie_set;
        logic        ie_clear;
    } hsc_core_type;

    // what the controller tells the core on wake-up
    typedef struct packed {
        logic        load;
        logic [11:0] target;
        logic        to_isr;
    } hsc_resume_type;

endpackage

/* hsc_clock_gate.sv */
// glitch-free clock gate for the core clock domain
// assumes enable is registered on the rising edge of the source clock
`timescale 1ns/1ps

module hsc_clock_gate
    import hsc_pkg::*;
(
    // clock source
    input  wire logic clk_src,
    // gate control
    input  wire logic enable,
    // gated output
    output logic      clk_gated
);

    logic latch_en;

    // latch transparent while clock low, so enable changes never cut a pulse
    always_latch begin
        if (!clk_src) begin
            latch_en = enable;
        end
    end

    assign clk_gated = clk_src & latch_en;

endmodule

/* hsc_halt_ctrl.sv */
// halt standby controller: halt entry, clock gating, wake on interrupt or reset
// assumes sys_clk is the always-running oscillator and the core runs on core_clk
`timescale 1ns/1ps

module hsc_halt_ctrl
    import hsc_pkg::*;
(
    // clock and reset
    input  wire logic     sys_clk,
    input  wire logic     rstn,
    // external interrupt pin
    input  wire logic     ext_int_n,
    // core interface
    input  hsc_core_type  core_in,
    output hsc_resume_type resume,
    // clock and status
    output logic          core_clk,
    output logic          core_clk_en,
    output logic          halted,
    output logic          interrupts_enabled_state,
    output logic          interrupts_disabled_state,
    output logic          core_reset_n
);

    // overview: the core runs on core_clk, a gated copy of sys_clk;
    // an executed halt opcode drops the gate enable at the next edge, while
    // the oscillator and this block keep running; a low interrupt pin, seen
    // through the synchroniser, raises the enable again, and one cycle later
    // the resume record tells the core where to continue; reset ends it all
    // asynchronously

    // sequencer: run, halt, wake
    hsc_state_type  state;
    hsc_state_type  next_state;
    logic [11:0]    resume_pc;
    logic [11:0]    next_resume_pc;
    logic           clk_en;
    logic           next_clk_en;

    // interrupt pin synchroniser and interrupt enable
    logic [1:0]     int_sync;
    logic [1:0]     next_int_sync;
    logic           ie;
    logic           next_ie;

    // resume record and reset release toward the core
    hsc_resume_type res_q;
    hsc_resume_type next_res;
    logic           rst_q;
    logic           next_rst;

    // decoded events, both in the sys_clk domain
    logic           int_req;
    logic           halt_hit;

    // the pin is asynchronous to sys_clk, so it crosses two flops first;
    // only the second flop is read, the first may still be settling;
    // the two-cycle lag is the price of a metastability-safe wake
    always_comb begin
        next_int_sync = {int_sync[0], ext_int_n};
    end

    // synchroniser resets to the idle high level, so no false wake follows reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            int_sync <= SYNC_RESET;
        end else begin
            int_sync <= next_int_sync;
        end
    end

    // a low level on the pin, not an edge, asks for the wake;
    // limitation: a pin that went high under two cycles before a new halt
    // may still be seen low and wake the core at once
    assign int_req  = ~int_sync[1];
    // only an executed opcode counts; a fetch that is not executed does not halt
    assign halt_hit = core_in.exec && (core_in.opcode == HALT_OPCODE);

    // interrupt enable follows the core's enable and disable instructions;
    // frozen outside run, so halt keeps the value it had before the opcode;
    // clear is applied last and so wins when both arrive in one cycle
    always_comb begin
        next_ie = ie;
        if (state == HSC_RUN) begin
            if (core_in.ie_set) begin
                next_ie = 1'b1;
            end
            if (core_in.ie_clear) begin
                next_ie = 1'b0;
            end
        end
    end

    // enable flop; a reset leaves interrupts disabled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ie <= IE_RESET;
        end else begin
            ie <= next_ie;
        end
    end

    // halt entry and wake sequencing; the gate enable changes only here,
    // always on a sys_clk rising edge, which the gate needs for clean pulses
    always_comb begin
        next_state     = state;
        next_resume_pc = resume_pc;
        next_clk_en    = clk_en;
        case (state)
            HSC_RUN: begin
                // keep the address after the opcode for a wake with interrupts off
                if (halt_hit) begin
                    next_state     = HSC_HALT;
                    next_resume_pc = core_in.next_pc;
                    next_clk_en    = 1'b0;
                end
            end
            HSC_HALT: begin
                // nothing but the interrupt pin leaves here; reset is async;
                // the pin wakes the core whether or not interrupts are enabled
                if (int_req) begin
                    next_state  = HSC_WAKE;
                    next_clk_en = 1'b1;
                end
            end
            HSC_WAKE: begin
                // clocks run again; the core is not expected to execute in this
                // cycle, so a halt opcode here would go unseen
                next_state = HSC_RUN;
            end
            default: begin
                // an unused code recovers to run with the clock on, never a lock-up
                next_state  = HSC_RUN;
                next_clk_en = 1'b1;
            end
        endcase
    end

    // sequencer flops; a reset forces run with the core clock on;
    // clk_en only moves on a rising edge, the gate's latch does the rest
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state     <= HSC_RUN;
            resume_pc <= PC_RESET;
            clk_en    <= 1'b1;
        end else begin
            state     <= next_state;
            resume_pc <= next_resume_pc;
            clk_en    <= next_clk_en;
        end
    end

    // resume record: one load pulse in the cycle after the clocks return;
    // the target depends on the enable that was frozen through halt
    always_comb begin
        next_res = '0;
        if (state == HSC_WAKE) begin
            next_res.load   = 1'b1;
            next_res.to_isr = ie;
            if (ie) begin
                next_res.target = EXT_INT_VECTOR;
            end else begin
                next_res.target = resume_pc;
            end
        end
    end

    // resume flops; registered so the core sees a clean one-cycle pulse;
    // the reset value points the core at address zero
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            res_q.load   <= 1'b0;
            res_q.target <= RESET_VECTOR;
            res_q.to_isr <= 1'b0;
        end else begin
            res_q <= next_res;
        end
    end

    // reset release to the core: low through rstn and until the first edge after,
    // so the core leaves reset on a whole clock and starts from address zero
    assign next_rst = 1'b1;

    // release flop; its reset value is the only low it ever holds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_q <= 1'b0;
        end else begin
            rst_q <= next_rst;
        end
    end

    // oscillator clock is never gated here, only the core branch is;
    // keeping the oscillator up trades some halt current for an instant wake,
    // with no restart or settling wait
    hsc_clock_gate u_gate (
        .clk_src   (sys_clk),
        .enable    (clk_en),
        .clk_gated (core_clk)
    );

    // resume record and clock enable, straight from flops
    assign resume                    = res_q;
    assign core_clk_en               = clk_en;

    // halt and enable status, level signals
    assign halted                    = (state == HSC_HALT);
    assign interrupts_enabled_state  = ie;
    assign interrupts_disabled_state = ~ie;

    // release toward the core
    assign core_reset_n              = rst_q;

endmodule

/* hsc_halt_properties.sv */
// port checks for the halt standby controller
// assumes it is bound onto hsc_halt_ctrl
`timescale 1ns/1ps
module hsc_halt_checker
    import hsc_pkg::*;
(
    // watched ports
    input wire logic           sys_clk,
    input wire logic           rstn,
    input wire logic           ext_int_n,
    input wire hsc_core_type   core_in,
    input wire hsc_resume_type resume,
    input wire logic           core_clk_en,
    input wire logic           halted,
    input wire logic           interrupts_enabled_state,
    input wire logic           interrupts_disabled_state,
    input wire logic           core_reset_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    halt_entry_a: assert property (core_in.exec && core_in.opcode == HALT_OPCODE && !halted
        |=> halted) else $error("halt opcode ignored");
    clock_stop_a: assert property (halted |-> !core_clk_en)
        else $error("core clock enabled in halt");
    state_hold_a: assert property (halted |=> $stable(interrupts_enabled_state))
        else $error("enable changed in halt");
    halt_hold_a: assert property (halted && ext_int_n && $past(ext_int_n)
        && $past(ext_int_n, 2) |=> halted) else $error("halt left without cause");
    int_wake_a: assert property (halted && !ext_int_n ##1 !ext_int_n
        |-> ##[1:4] core_clk_en) else $error("no wake on interrupt");
    resume_kind_a: assert property ($rose(core_clk_en) |=> resume.load
        && resume.to_isr == interrupts_enabled_state) else $error("bad resume");
    isr_vector_a: assert property (resume.load && resume.to_isr
        |-> resume.target == EXT_INT_VECTOR) else $error("bad vector");
    ie_pair_a: assert property (interrupts_disabled_state != interrupts_enabled_state)
        else $error("enable states disagree");
    reset_init_a: assert property (disable iff (1'b0) !rstn && !$past(rstn)
        |-> !halted && !core_reset_n && !interrupts_enabled_state) else $error("bad reset");
    di_wake_c: cover property (resume.load && !resume.to_isr);
    ei_wake_c: cover property (resume.load && resume.to_isr);
    halt_c: cover property (disable iff (1'b0) halted ##1 !rstn);
endmodule
bind hsc_halt_ctrl hsc_halt_checker chk (.*);

/* hsc_ext_party.sv */
// far-side model: interrupt source and reset circuit
// assumes requests come from the bench on sys_clk edges
`timescale 1ns/1ps
module hsc_ext_party (
    // requests
    input  wire logic sys_clk,
    input  wire logic int_req,
    input  wire logic rst_req,
    // pins, pulled high when idle
    output logic      ext_int_n,
    output logic      rstn
);
    initial ext_int_n = 1'b1;
    initial rstn = 1'b0;
    // pins move just after the edge, like a board driver
    always @(posedge sys_clk) begin
        ext_int_n <= !int_req;
        rstn <= !rst_req;
    end
endmodule

/* test_halt_standby_control.sv */
// bench for the halt standby controller
// assumes package, design, checker and far-side model compiled first
`timescale 1ns/1ps
module test_halt_standby_control;
    import hsc_pkg::*;
    logic           sys_clk = 0, int_req = 0, rst_req = 1, ext_int_n, rstn;
    logic           core_clk, core_clk_en, halted, ie, idis, crn;
    hsc_core_type   core_in = '0;
    hsc_resume_type resume;
    int             err_total = 0, compares = 0, gclk = 0;
    hsc_ext_party far (.sys_clk(sys_clk), .int_req(int_req), .rst_req(rst_req),
        .ext_int_n(ext_int_n), .rstn(rstn));
    hsc_halt_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .ext_int_n(ext_int_n),
        .core_in(core_in), .resume(resume), .core_clk(core_clk), .core_clk_en(core_clk_en),
        .halted(halted), .interrupts_enabled_state(ie), .interrupts_disabled_state(idis),
        .core_reset_n(crn));
    initial forever #4 sys_clk = ~sys_clk;
    // gated edges show whether the core really stopped
    always @(posedge core_clk) gclk++;
    task automatic check(logic [11:0] got, logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic do_halt(logic [11:0] pc);
        core_in <= '{1'b1, HALT_OPCODE, pc, 1'b0, 1'b0};
        step(1);
        core_in <= '0;
        step(2);
        check(halted, 1);
    endtask
    // interrupt stays low until the resume pulse, longer than the 3 cycles needed
    task automatic wake(logic [11:0] tgt, logic isr);
        int n;
        int_req <= 1;
        for (n = 0; n < 20 && resume.load !== 1'b1; n++) step(1);
        check(resume.target, tgt);
        check(resume.to_isr, isr);
        int_req <= 0;
        step(2);
        check(halted, 0);
        check(resume.load, 0);
    endtask
    task automatic test_di;
        int n;
        do_halt(12'h3ff);
        n = gclk;
        core_in <= '{1'b1, 8'h00, 12'h0, 1'b1, 1'b0};
        step(1);
        core_in <= '0;
        step(4);
        check(halted, 1);
        check(ie, 0);
        check(gclk, n);
        check(core_clk_en, 0);
        check(idis, 1);
        wake(12'h3ff, 0);
        check(gclk > n, 1);
        $display("test_di done");
    endtask
    task automatic test_ei;
        core_in <= '{1'b0, 8'h00, 12'h0, 1'b1, 1'b0};
        step(1);
        do_halt(12'h456);
        wake(EXT_INT_VECTOR, 1);
        $display("test_ei done");
    endtask
    task automatic test_rst;
        do_halt(12'h0a5);
        rst_req <= 1;
        step(3);
        check(halted, 0);
        check(ie, 0);
        check(crn, 0);
        rst_req <= 0;
        step(3);
        check(crn, 1);
        $display("test_rst done");
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(4);
        rst_req <= 0;
        step(3);
        check(crn, 1);
        test_di;
        test_ei;
        test_rst;
        finish_test;
    end
    // about fifty cycles are expected; 2500 means a hang
    initial begin
        #20us;
        err_total++;
        finish_test;
    end
endmodule
